// File: icatr_top.sv
// icatr_top: trigger/exposure sequencer, frame store and pixel reformatter
`timescale 1ns/100ps
module icatr_top #(
  parameter int MAX_W = 64,
  parameter int MAX_H = 64,
  parameter int SCAN_US = 1000
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // trigger pins, inputs 1 to 4
  input wire logic [3:0] gpio_in,
  // sensor side
  input icatr_pkg::icatr_pix_t pix,
  output logic sen_glob_reset,
  output logic sen_roll_start,
  output logic sen_integrate,
  output logic sen_readout,
  output logic sen_full_area,
  output logic flash_out,
  // reformatted pixel stream
  output icatr_pkg::icatr_out_t out,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(MAX_W * MAX_H);

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        o[8*i +: 8] = n[8*i +: 8];
      end
    end
    return o;
  endfunction

  function automatic logic [1:0] lg(input logic [2:0] f);
    return (f == 3'd4) ? 2'd2 : (f == 3'd2) ? 2'd1 : 2'd0;
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  icatr_pkg::icatr_ctrl_t ctrl, next_ctrl;
  logic [31:0] expo, next_expo;
  logic ovf, next_ovf, ovf_set;
  logic [15:0] cap_w, cap_h;
  icatr_pkg::icatr_est_t e_state, next_e_state;
  icatr_pkg::icatr_ost_t o_state, next_o_state;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wr_go, rd_go;

  assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

  always_comb begin
    next_ctrl = ctrl;
    next_expo = expo;
    next_ovf = ovf;
    next_awready = wr_go;
    next_wready = wr_go;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_arready = rd_go;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_bresp = icatr_pkg::RESP_OKAY;
      unique case (s_axi_awaddr)
        icatr_pkg::OFF_CTRL: next_ctrl = merge(ctrl, s_axi_wdata, s_axi_wstrb)
                                         & icatr_pkg::CTRL_WMASK;
        icatr_pkg::OFF_EXPO: next_expo = merge(expo, s_axi_wdata, s_axi_wstrb);
        icatr_pkg::OFF_STAT: begin
          if (s_axi_wstrb[0] && s_axi_wdata[icatr_pkg::STAT_OVF_BIT]) begin
            next_ovf = 1'b0;
          end
        end
        icatr_pkg::OFF_SIZE: ;
        default: next_bresp = icatr_pkg::RESP_SLVERR;
      endcase
    end
    if (ovf_set) begin
      next_ovf = 1'b1;
    end
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp = icatr_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        icatr_pkg::OFF_CTRL: next_rdata = ctrl;
        icatr_pkg::OFF_EXPO: next_rdata = expo;
        icatr_pkg::OFF_STAT: next_rdata = {27'h0, ovf, e_state, o_state != icatr_pkg::O_IDLE};
        icatr_pkg::OFF_SIZE: next_rdata = {cap_h, cap_w};
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = icatr_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= icatr_pkg::CTRL_RST;
      expo <= icatr_pkg::EXPO_RST;
      ovf <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= icatr_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= icatr_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      expo <= next_expo;
      ovf <= next_ovf;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // trigger and exposure sequencer
  // ----------------------------------------
  logic [3:0] gp_s1, gp_s2, gp_s3;
  logic trig_lvl, trig_rise, lval_d, fval_d, lval_fall, fval_fall, align_ok;
  logic [7:0] tick, next_tick;
  logic [25:0] e_us, next_e_us, e_len, next_e_len;
  logic e_pw, next_e_pw, e_roll, next_e_roll, e_fdly, next_e_fdly;
  logic next_glob, next_roll, next_int, next_rd, next_flash;
  logic [25:0] req_us;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gp_s1 <= 4'h0;
      gp_s2 <= 4'h0;
      gp_s3 <= 4'h0;
      lval_d <= 1'b0;
      fval_d <= 1'b0;
    end else begin
      gp_s1 <= gpio_in;
      gp_s2 <= gp_s1;
      gp_s3 <= gp_s2;
      lval_d <= pix.lval;
      fval_d <= pix.fval;
    end
  end

  assign trig_lvl = gp_s2[2'(ctrl.trig_src - 3'd1)];
  assign trig_rise = trig_lvl && !gp_s3[2'(ctrl.trig_src - 3'd1)];
  assign lval_fall = lval_d && !pix.lval;
  assign fval_fall = fval_d && !pix.fval;
  assign align_ok = ctrl.rolling ? fval_fall : lval_fall;
  assign req_us = (expo[31:26] != 6'h00 || expo[25:0] > icatr_pkg::EXPO_MAX_US) ?
                  icatr_pkg::EXPO_MAX_US :
                  (expo[25:0] < icatr_pkg::EXPO_MIN_US) ? icatr_pkg::EXPO_MIN_US : expo[25:0];

  always_comb begin
    next_e_state = e_state;
    next_tick = tick;
    next_e_us = e_us;
    next_e_len = e_len;
    next_e_pw = e_pw;
    next_e_roll = e_roll;
    next_e_fdly = e_fdly;
    next_glob = 1'b0;
    next_roll = 1'b0;
    next_rd = 1'b0;
    next_int = sen_integrate;
    next_flash = flash_out;
    unique case (e_state)
      icatr_pkg::E_IDLE: begin
        next_tick = 8'h00;
        if (trig_rise && ctrl.acq_en) begin
          next_e_state = pix.fval ? icatr_pkg::E_ALIGN : icatr_pkg::E_DELAY;
        end
      end
      icatr_pkg::E_ALIGN: begin
        if (align_ok) begin
          next_e_state = icatr_pkg::E_EXPO;
        end
      end
      icatr_pkg::E_DELAY: begin
        next_tick = tick + 8'h01;
        if (tick == 8'(icatr_pkg::TRIG_DLY_CYC - 1)) begin
          next_e_state = icatr_pkg::E_EXPO;
        end
      end
      icatr_pkg::E_EXPO: begin
        next_tick = (tick == 8'(icatr_pkg::US_CYC - 1)) ? 8'h00 : tick + 8'h01;
        if (tick == 8'(icatr_pkg::US_CYC - 1)) begin
          next_e_us = e_us + 26'd1;
        end
        if (e_roll && e_fdly) begin
          next_flash = e_us >= 26'(SCAN_US);
        end
        if (e_pw ? !trig_lvl : (e_us >= e_len)) begin
          next_e_state = icatr_pkg::E_IDLE;
          next_int = 1'b0;
          next_flash = 1'b0;
          next_rd = 1'b1;
        end
      end
      default: next_e_state = icatr_pkg::E_IDLE;
    endcase
    if (next_e_state == icatr_pkg::E_EXPO && e_state != icatr_pkg::E_EXPO) begin
      next_tick = 8'h00;
      next_e_us = 26'd0;
      next_e_len = req_us;
      next_e_roll = ctrl.rolling;
      next_e_pw = ctrl.pulse_width && !ctrl.rolling;
      next_e_fdly = ctrl.flash_delay;
      next_glob = !ctrl.rolling;
      next_roll = ctrl.rolling;
      next_int = 1'b1;
      next_flash = !(ctrl.rolling && ctrl.flash_delay);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      e_state <= icatr_pkg::E_IDLE;
      tick <= 8'h00;
      e_us <= 26'd0;
      e_len <= 26'd0;
      e_pw <= 1'b0;
      e_roll <= 1'b0;
      e_fdly <= 1'b0;
      sen_glob_reset <= 1'b0;
      sen_roll_start <= 1'b0;
      sen_integrate <= 1'b0;
      sen_readout <= 1'b0;
      sen_full_area <= 1'b0;
      flash_out <= 1'b0;
    end else begin
      e_state <= next_e_state;
      tick <= next_tick;
      e_us <= next_e_us;
      e_len <= next_e_len;
      e_pw <= next_e_pw;
      e_roll <= next_e_roll;
      e_fdly <= next_e_fdly;
      sen_glob_reset <= next_glob;
      sen_roll_start <= next_roll;
      sen_integrate <= next_int;
      sen_readout <= next_rd;
      sen_full_area <= ctrl.rolling;
      flash_out <= next_flash;
    end
  end

  // ----------------------------------------
  // frame store capture
  // ----------------------------------------
  localparam int PIX_W_L = icatr_pkg::PIX_W;
  logic [PIX_W_L-1:0] mem [MAX_W * MAX_H];
  logic [15:0] cx_in, cy_in;
  logic [1:0] sub3;
  logic cap_ok, keep, o_idle;

  assign o_idle = o_state == icatr_pkg::O_IDLE;
  assign keep = !(ctrl.bin_2x2 && ctrl.dval_en) || sub3 == 2'd0;
  assign ovf_set = pix.fval && !fval_d && !o_idle;

  always_ff @(posedge aclk) begin
    if (pix.valid && pix.lval && cap_ok && keep && cx_in < 16'(MAX_W) && cy_in < 16'(MAX_H)) begin
      mem[AW'(32'(cy_in) * MAX_W + 32'(cx_in))] <= pix.data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cx_in <= 16'h0000;
      cy_in <= 16'h0000;
      sub3 <= 2'd0;
      cap_ok <= 1'b0;
      cap_w <= 16'h0000;
      cap_h <= 16'h0000;
    end else begin
      if (pix.fval && !fval_d) begin
        cap_ok <= o_idle;
        cy_in <= 16'h0000;
      end
      if (pix.valid && pix.lval && cap_ok) begin
        sub3 <= (sub3 == 2'd2) ? 2'd0 : sub3 + 2'd1;
        if (keep && cx_in < 16'(MAX_W)) begin
          cx_in <= cx_in + 16'h0001;
        end
      end
      if (lval_fall && cap_ok) begin
        cap_w <= cx_in;
        cx_in <= 16'h0000;
        sub3 <= 2'd0;
        cy_in <= (cy_in < 16'(MAX_H)) ? cy_in + 16'h0001 : cy_in;
      end
      if (fval_fall && cap_ok) begin
        cap_h <= cy_in;
        cap_ok <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // reformatter: bin, decimate, mirror
  // ----------------------------------------
  logic start;
  logic [2:0] bh, bv, cx, cy, next_cx, next_cy;
  logic [15:0] sx, sy, bx, by, next_bx, next_by, rx, ry;
  logic [3:0] shift;
  logic [icatr_pkg::OUT_W-1:0] acc, next_acc, sum;
  icatr_pkg::icatr_out_t next_out;
  logic next_ovalid;

  assign start = fval_fall && cap_ok;
  assign bh = (ctrl.bin_2x2) ? 3'd2 : ctrl.bin_h ? ctrl.bin_factor : 3'd1;
  assign bv = (ctrl.bin_2x2) ? 3'd2 : ctrl.bin_v ? ctrl.bin_factor : 3'd1;
  assign sx = {13'h0, bh} << ctrl.decim_x;
  assign sy = {13'h0, bv} << ctrl.decim_y;
  assign shift = {2'b00, lg(bh)} + {2'b00, lg(bv)};
  assign rx = ctrl.mirror_x ? cap_w - 16'h0001 - (bx + 16'(cx)) : bx + 16'(cx);
  assign ry = ctrl.mirror_y ? cap_h - 16'h0001 - (by + 16'(cy)) : by + 16'(cy);
  assign sum = acc + icatr_pkg::OUT_W'(mem[AW'(32'(ry) * MAX_W + 32'(rx))]);

  always_comb begin
    next_o_state = o_state;
    next_cx = cx;
    next_cy = cy;
    next_bx = bx;
    next_by = by;
    next_acc = acc;
    next_out = out;
    next_ovalid = out_valid;
    unique case (o_state)
      icatr_pkg::O_IDLE: begin
        if (start && cap_w >= sx && cy_in >= sy) begin
          next_o_state = icatr_pkg::O_ACC;
          next_bx = 16'h0000;
          next_by = 16'h0000;
          next_cx = 3'd0;
          next_cy = 3'd0;
          next_acc = '0;
        end
      end
      icatr_pkg::O_ACC: begin
        next_acc = sum;
        if (cx != bh - 3'd1) begin
          next_cx = cx + 3'd1;
        end else if (cy != bv - 3'd1) begin
          next_cx = 3'd0;
          next_cy = cy + 3'd1;
        end else begin
          next_o_state = icatr_pkg::O_SEND;
          next_ovalid = 1'b1;
          next_out.data = ctrl.bin_sum ? sum : sum >> shift;
          next_out.eol = bx + sx + sx > cap_w;
          next_out.eof = (bx + sx + sx > cap_w) && (by + sy + sy > cap_h);
        end
      end
      icatr_pkg::O_SEND: begin
        if (out_ready) begin
          next_ovalid = 1'b0;
          next_cx = 3'd0;
          next_cy = 3'd0;
          next_acc = '0;
          next_o_state = out.eof ? icatr_pkg::O_IDLE : icatr_pkg::O_ACC;
          next_bx = out.eol ? 16'h0000 : bx + sx;
          next_by = out.eol ? by + sy : by;
        end
      end
      default: next_o_state = icatr_pkg::O_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      o_state <= icatr_pkg::O_IDLE;
      cx <= 3'd0;
      cy <= 3'd0;
      bx <= 16'h0000;
      by <= 16'h0000;
      acc <= '0;
      out <= '0;
      out_valid <= 1'b0;
    end else begin
      o_state <= next_o_state;
      cx <= next_cx;
      cy <= next_cy;
      bx <= next_bx;
      by <= next_by;
      acc <= next_acc;
      out <= next_out;
      out_valid <= next_ovalid;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_trig_in_frame;
    e_state == icatr_pkg::E_IDLE && trig_rise && ctrl.acq_en && pix.fval && !ctrl.rolling;
  endsequence
  property p_trig_align;
    @(posedge aclk) disable iff (!aresetn)
      s_trig_in_frame |=> e_state == icatr_pkg::E_ALIGN;
  endproperty
  a_trig_align: assert property (p_trig_align) else $error("trigger in frame not held");
  property p_align_lval;
    @(posedge aclk) disable iff (!aresetn)
      e_state == icatr_pkg::E_ALIGN && !ctrl.rolling && lval_fall
      |=> e_state == icatr_pkg::E_EXPO && sen_integrate;
  endproperty
  a_align_lval: assert property (p_align_lval) else $error("no start on line end");
  property p_idle_delay;
    @(posedge aclk) disable iff (!aresetn)
      e_state == icatr_pkg::E_IDLE && trig_rise && ctrl.acq_en && !pix.fval
      |=> e_state == icatr_pkg::E_DELAY ##[1:200] e_state == icatr_pkg::E_EXPO;
  endproperty
  a_idle_delay: assert property (p_idle_delay) else $error("fixed delay wrong");
  property p_pw_end;
    @(posedge aclk) disable iff (!aresetn)
      e_state == icatr_pkg::E_EXPO && e_pw && !trig_lvl |=> sen_readout && !sen_integrate;
  endproperty
  a_pw_end: assert property (p_pw_end) else $error("pulse width end missed");
  property p_roll_no_pw;
    @(posedge aclk) disable iff (!aresetn)
      e_state == icatr_pkg::E_EXPO && e_roll |-> !e_pw;
  endproperty
  a_roll_no_pw: assert property (p_roll_no_pw) else $error("pulse width in rolling");
  property p_glob_reset;
    @(posedge aclk) disable iff (!aresetn)
      $rose(sen_integrate) && !e_roll |-> sen_glob_reset && !sen_roll_start;
  endproperty
  a_glob_reset: assert property (p_glob_reset) else $error("no global reset");
  property p_flash_dly;
    @(posedge aclk) disable iff (!aresetn)
      flash_out && e_roll && e_fdly |-> e_us >= 26'(SCAN_US);
  endproperty
  a_flash_dly: assert property (p_flash_dly) else $error("flash too early");
  property p_len_stable;
    @(posedge aclk) disable iff (!aresetn)
      e_state == icatr_pkg::E_EXPO && $past(e_state) == icatr_pkg::E_EXPO
      |-> $stable(e_len) && e_len >= icatr_pkg::EXPO_MIN_US && e_len <= icatr_pkg::EXPO_MAX_US;
  endproperty
  a_len_stable: assert property (p_len_stable) else $error("exposure length moved");
  property p_out_hold;
    @(posedge aclk) disable iff (!aresetn)
      out_valid && !out_ready |=> out_valid && $stable(out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output dropped");
endmodule

// File: icatr_pkg.sv
// icatr_pkg: constants, register layout and types for the capture/reformat block
package icatr_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_EXPO = 5'h04;
  localparam logic [4:0] OFF_STAT = 5'h08;
  localparam logic [4:0] OFF_SIZE = 5'h0C;
  localparam logic [31:0] CTRL_RST = 32'h0011_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0077_1FFF;
  localparam logic [31:0] EXPO_RST = 32'h0000_03E8;
  localparam int STAT_OVF_BIT = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PS = 5000;
  localparam int US_PS = 1000000;
  localparam int US_CYC = US_PS / CLK_PS;
  localparam int TRIG_DLY_NS = 500;
  localparam int TRIG_DLY_CYC = (TRIG_DLY_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam logic [25:0] EXPO_MIN_US = 26'd60;
  localparam logic [25:0] EXPO_MAX_US = 26'd60000000;
  localparam int PIX_W = 12;
  localparam int OUT_W = PIX_W + 4;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [8:0] rsvd_hi;
    logic [2:0] trig_src;
    logic rsvd_a;
    logic [2:0] bin_factor;
    logic [2:0] rsvd_b;
    logic flash_delay;
    logic rolling;
    logic pulse_width;
    logic decim_y;
    logic decim_x;
    logic dval_en;
    logic bin_sum;
    logic bin_2x2;
    logic bin_v;
    logic bin_h;
    logic mirror_y;
    logic mirror_x;
    logic acq_en;
  } icatr_ctrl_t;
  typedef struct packed {
    logic fval;
    logic lval;
    logic valid;
    logic [PIX_W-1:0] data;
  } icatr_pix_t;
  typedef struct packed {
    logic eof;
    logic eol;
    logic [OUT_W-1:0] data;
  } icatr_out_t;
  typedef enum logic [2:0] {
    E_IDLE = 3'b000, E_ALIGN = 3'b001, E_DELAY = 3'b010, E_EXPO = 3'b011
  } icatr_est_t;
  typedef enum logic [1:0] {
    O_IDLE = 2'b00, O_ACC = 2'b01, O_SEND = 2'b10
  } icatr_ost_t;
endpackage

// File: icatr_sensor_model.sv
// icatr_sensor_model: sensor readout stream and trigger pin source
`timescale 1ns/100ps
module icatr_sensor_model (
  // clock
  input wire logic aclk,
  // sensor stream and trigger pins
  output icatr_pkg::icatr_pix_t pix,
  output logic [3:0] gpio_in
);
  initial begin
    pix = '0;
    gpio_in = '0;
  end
  // data toggles on each idle cycle, with no pixel valid
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge aclk);
      pix.lval <= 1'b0;
      pix.valid <= 1'b0;
      pix.data <= ~pix.data;
    end
  endtask
  task automatic frame(input int w, input int h);
    @(posedge aclk);
    pix.fval <= 1'b1;
    pix.data <= ~pix.data;
    for (int y = 0; y < h; y++) begin
      for (int x = 0; x < w; x++) begin
        @(posedge aclk);
        pix.lval <= 1'b1;
        pix.valid <= 1'b1;
        pix.data <= 12'(y * 16 + x + 1);
      end
      idle(4);
    end
    @(posedge aclk);
    pix.fval <= 1'b0;
    pix.data <= ~pix.data;
  endtask
  task automatic trig(input int b, input int len);
    @(posedge aclk);
    gpio_in[b] <= 1'b1;
    repeat (len) @(posedge aclk);
    gpio_in[b] <= 1'b0;
  endtask
endmodule

// File: test_image_capture_trigger_and_reformat.sv
// test_image_capture_trigger_and_reformat: self-checking bench for icatr_top
`timescale 1ns/100ps
module test_image_capture_trigger_and_reformat;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, gpio_in;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic sen_glob_reset, sen_roll_start, sen_integrate, sen_readout, sen_full_area, flash_out;
  logic out_valid, out_ready;
  icatr_pkg::icatr_pix_t pix;
  icatr_pkg::icatr_out_t out;
  icatr_pkg::icatr_out_t got[$];
  int num_errors, cmp_count, cyc, t_trg, t_rise, t_fall, t_flash, t_lfall, d_al;
  bit g_seen, r_seen;

  icatr_top #(.MAX_W(8), .MAX_H(8), .SCAN_US(1)) uut (.*);
  icatr_sensor_model sen (.*);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // ----------------------------------------
  // monitors; host link stalls every other cycle
  // ----------------------------------------
  always @(posedge aclk) begin
    cyc++;
    if (out_valid && out_ready) got.push_back(out);
    out_ready <= ~out_ready;
  end
  always @(posedge sen_integrate) begin
    t_rise = cyc;
    d_al = cyc - t_lfall;
  end
  always @(negedge sen_integrate) t_fall = cyc;
  always @(posedge flash_out) t_flash = cyc;
  always @(negedge pix.lval) t_lfall = cyc;
  always @(posedge gpio_in[0] or posedge gpio_in[1]) t_trg = cyc;
  always @(posedge sen_glob_reset) g_seen = 1'b1;
  always @(posedge sen_roll_start) r_seen = 1'b1;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic final_report();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    cmp_count++;
    if (!ok) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      num_errors++;
      $display("[ERR] %0t wait ran out", $time);
      final_report();
    end
  endtask
  task automatic axw(input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
    tmo(n, 100);
  endtask
  task automatic axr(input logic [4:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    tmo(n, 100);
  endtask
  task automatic wexp();
    int n;
    n = 0;
    while (t_fall <= t_rise && n < 20000) begin
      @(posedge aclk);
      n++;
    end
    tmo(n, 20000);
  endtask
  // one 8x4 frame, output compared with a model of the reformatter
  task automatic run_frame(input logic [31:0] v);
    icatr_pkg::icatr_ctrl_t c;
    icatr_pkg::icatr_out_t e[$];
    int sx, sy, nc, nr, bh, bv, s, x, y, n;
    c = v;
    sx = (c.bin_2x2 && c.dval_en) ? 3 : (c.decim_x ? 2 : 1);
    sy = c.decim_y ? 2 : 1;
    nc = (8 + sx - 1) / sx;
    nr = (4 + sy - 1) / sy;
    bh = c.bin_2x2 ? 2 : (c.bin_h ? int'(c.bin_factor) : 1);
    bv = c.bin_2x2 ? 2 : (c.bin_v ? int'(c.bin_factor) : 1);
    for (int r = 0; r < nr / bv; r++) begin
      for (int q = 0; q < nc / bh; q++) begin
        s = 0;
        for (int k = 0; k < bh * bv; k++) begin
          x = q * bh + k % bh;
          y = r * bv + k / bh;
          x = c.mirror_x ? nc - 1 - x : x;
          y = c.mirror_y ? nr - 1 - y : y;
          s += y * sy * 16 + x * sx + 1;
        end
        e.push_back('{1'b0, 1'(q == nc / bh - 1), 16'(c.bin_sum ? s : s >> $clog2(bh * bv))});
      end
    end
    e[$].eof = 1'b1;
    axw(icatr_pkg::OFF_CTRL, v);
    got.delete();
    sen.frame(8, 4);
    n = 0;
    while (!(got.size() > 0 && got[$].eof === 1'b1) && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    tmo(n, 3000);
    chk(got.size() == e.size(), "output pixel count");
    foreach (e[i]) chk(got[i] === e[i], "output pixel");
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic sc_regs();
    axr(icatr_pkg::OFF_CTRL);
    chk(rd === icatr_pkg::CTRL_RST, "ctrl reset value");
    axr(icatr_pkg::OFF_EXPO);
    chk(rd === icatr_pkg::EXPO_RST, "exposure reset value");
    axw(icatr_pkg::OFF_EXPO, 32'h0000_0001);
    axr(icatr_pkg::OFF_EXPO);
    chk(rd === 32'h0000_0001, "exposure readback");
    axr(5'h10);
    chk(rsp === icatr_pkg::RESP_SLVERR && rd === 32'h0000_0000, "unmapped read");
    axw(5'h10, 32'h0000_0001);
    chk(rsp === icatr_pkg::RESP_SLVERR, "unmapped write");
  endtask
  task automatic sc_format();
    run_frame(32'h0011_0001);
    run_frame(32'h0011_0003);
    run_frame(32'h0011_0005);
    run_frame(32'h0012_0009);
    run_frame(32'h0014_0049);
    run_frame(32'h0014_0051);
    run_frame(32'h0011_0021);
    run_frame(32'h0011_00A1);
    run_frame(32'h0011_0101);
    run_frame(32'h0011_0201);
    axr(icatr_pkg::OFF_SIZE);
    chk(rd === 32'h0004_0008, "captured size");
    axr(icatr_pkg::OFF_STAT);
    chk(rd === 32'h0000_0000, "status idle");
  endtask
  task automatic sc_trig_idle();
    axw(icatr_pkg::OFF_CTRL, 32'h0011_0001);
    t_rise = 0;
    t_fall = 0;
    g_seen = 1'b0;
    sen.trig(1, 10);
    repeat (150) @(posedge aclk);
    chk(t_rise == 0, "unselected input ignored");
    sen.trig(0, 10);
    repeat (300) @(posedge aclk);
    axw(icatr_pkg::OFF_EXPO, 32'h0000_0064);
    wexp();
    chk(t_rise - t_trg >= icatr_pkg::TRIG_DLY_CYC, "idle delay short");
    chk(t_rise - t_trg <= icatr_pkg::TRIG_DLY_CYC + 6, "idle delay long");
    chk(t_fall - t_rise >= 60 * icatr_pkg::US_CYC, "exposure short");
    chk(t_fall - t_rise <= 61 * icatr_pkg::US_CYC + 2, "exposure long");
    chk(g_seen, "global reset pulse");
  endtask
  task automatic sc_overlap();
    axw(icatr_pkg::OFF_EXPO, 32'h0000_003C);
    t_fall = 0;
    fork
      begin
        sen.frame(8, 4);
        sen.frame(8, 4);
      end
      begin
        repeat (12) @(posedge aclk);
        sen.trig(0, 10);
      end
    join
    wexp();
    chk(d_al >= 1 && d_al <= 3, "start aligned to line end");
    axr(icatr_pkg::OFF_STAT);
    chk(rd === 32'h0000_0010, "overflow flag set");
    axw(icatr_pkg::OFF_STAT, 32'h0000_0010);
    axr(icatr_pkg::OFF_STAT);
    chk(rd === 32'h0000_0000, "overflow flag cleared");
  endtask
  task automatic sc_pulse();
    axw(icatr_pkg::OFF_CTRL, 32'h0021_0401);
    t_fall = 0;
    sen.trig(1, 400);
    wexp();
    chk(t_fall - t_trg >= 400 && t_fall - t_trg <= 406, "pulse width end");
  endtask
  task automatic sc_roll();
    axw(icatr_pkg::OFF_CTRL, 32'h0011_1C01);
    t_fall = 0;
    r_seen = 1'b0;
    sen.trig(0, 50);
    wexp();
    chk(r_seen && sen_full_area === 1'b1, "rolling start, full area");
    chk(t_fall - t_rise >= 60 * icatr_pkg::US_CYC, "rolling ignores pulse");
    chk(t_flash - t_rise >= icatr_pkg::US_CYC - 2, "flash early");
    chk(t_flash - t_rise <= icatr_pkg::US_CYC + 2, "flash late");
  endtask

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    out_ready = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    sc_regs();
    sc_format();
    sc_trig_idle();
    sc_overlap();
    sc_pulse();
    sc_roll();
    final_report();
  end
endmodule
